// ### pkg/pfc_pkg.sv
// Constants and types for the port J/K/L pin function control block.
// Assumes a single 40 MHz clock and an Avalon-MM register slave.
//
// Functional notes
// - Port J select register is 16-bit RW, eight 2-bit fields, reset zero.
// - Port J code 00 routes to dedicated alternate function, 01 port output.
// - Port K select register is 16-bit RW, eight 2-bit fields, reset zero.
// - On ports K and L code 00 connects the alternate peripheral function.
// - On port K code 01 makes the pin a general output.
// - On port K code 10 makes the pin an input with pull-up on.
// - On ports K and L code 11 makes an input with pull-up off.
// - Port L register low byte holds four 2-bit fields, reset zero.
// - Port L bits 15 to 8 are read-only and always read zero.
package pfc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int unsigned PFC_ADDR_W = 5;
   localparam int unsigned PFC_DATA_W = 32;
   localparam int unsigned PFC_REG_W = 16;
   localparam int unsigned PFC_MODE_W = 2;

   // Byte offsets of the registers
   localparam logic [4:0] PFC_OFS_J = 5'h00;
   localparam logic [4:0] PFC_OFS_K = 5'h04;
   localparam logic [4:0] PFC_OFS_L = 5'h08;
   localparam logic [4:0] PFC_OFS_STAT = 5'h0C;
   localparam logic [4:0] PFC_OFS_SUMMARY = 5'h10;

   // Reset values
   localparam logic [15:0] PFC_RST_J = 16'h0000;
   localparam logic [15:0] PFC_RST_K = 16'h0000;
   localparam logic [15:0] PFC_RST_L = 16'h0000;
   localparam logic [3:0] PFC_RST_STAT = 4'h0;
   localparam logic [31:0] PFC_RDATA_ZERO = 32'h0000_0000;

   // Writable bits of each select register
   localparam logic [15:0] PFC_MASK_J = 16'hFFFF;
   localparam logic [15:0] PFC_MASK_K = 16'hFFFF;
   localparam logic [15:0] PFC_MASK_L = 16'h00FF;

   // Pin counts
   localparam int unsigned PFC_PINS_J = 8;
   localparam int unsigned PFC_PINS_K = 8;
   localparam int unsigned PFC_PINS_L = 4;

   // Mode codes
   localparam logic [1:0] PFC_MODE_ALT = 2'h0;
   localparam logic [1:0] PFC_MODE_OUT = 2'h1;
   localparam logic [1:0] PFC_MODE_IN_PU = 2'h2;
   localparam logic [1:0] PFC_MODE_IN_NOPU = 2'h3;

   // Legal codes per port, one bit per code value
   localparam logic [3:0] PFC_ALLOW_J = 4'h3;
   localparam logic [3:0] PFC_ALLOW_K = 4'hF;
   localparam logic [3:0] PFC_ALLOW_L = 4'h9;

   // Status bit positions, write one to clear
   localparam int unsigned PFC_ST_J_BAD = 0;
   localparam int unsigned PFC_ST_L_BAD = 1;
   localparam int unsigned PFC_ST_L_RSV = 2;
   localparam int unsigned PFC_ST_UNMAP = 3;
   localparam int unsigned PFC_ST_W = 4;

   // Summary register field positions
   localparam int unsigned PFC_SUM_J_OUT = 0;
   localparam int unsigned PFC_SUM_K_OUT = 8;
   localparam int unsigned PFC_SUM_K_IN = 16;
   localparam int unsigned PFC_SUM_L_IN = 24;

   ////////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic {PFC_IDLE, PFC_ACK} pfc_bus_state_t;

   typedef struct packed {
      logic [7:0] alt_sel;
      logic [7:0] out_en;
      logic [7:0] in_en;
      logic [7:0] pull_up;
   } pfc_pin_ctl_t;

   typedef struct packed {
      pfc_bus_state_t bus;
      logic [15:0] j_sel;
      logic [15:0] k_sel;
      logic [15:0] l_sel;
      logic [3:0] status;
      logic [31:0] rdata;
   } pfc_state_t;

endpackage

// ### design/pfc_mode_decode.sv
// Per-pin decoder from a 16-bit mode select word to pin routing controls.
// Assumes the select word comes straight from flip-flops on the same clock.
`timescale 1ns/100ps

module pfc_mode_decode #(
   parameter int unsigned NPINS = 8,
   parameter logic [3:0] ALLOW = 4'hF
) (
   // Select word
   input wire logic [15:0] sel_in,
   // Decoded controls
   output pfc_pkg::pfc_pin_ctl_t ctl_out
);
   import pfc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // A prohibited code leaves the pin idle, which is the least harmful choice
   always_comb begin
      logic [1:0] code;
      code = 2'h0;
      ctl_out = '0;
      for (int i = 0; i < 8; i++) begin
         code = sel_in[2*i +: 2];
         if ((i < NPINS) && ALLOW[code]) begin
            ctl_out.alt_sel[i] = (code == PFC_MODE_ALT);
            ctl_out.out_en[i] = (code == PFC_MODE_OUT);
            ctl_out.in_en[i] = code[1];
            ctl_out.pull_up[i] = (code == PFC_MODE_IN_PU);
         end
      end
   end

endmodule

// ### design/pfc_top.sv
// Pin function control for ports J, K and L, with an Avalon-MM register slave.
// Assumes one master, ref_clk_in at 40 MHz, and pad logic that obeys the
// decoded per-pin controls (alternate, output, input, pull-up).
`timescale 1ns/100ps

module pfc_top (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   // Avalon-MM slave
   input wire logic [pfc_pkg::PFC_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [pfc_pkg::PFC_DATA_W-1:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [pfc_pkg::PFC_DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Pin controls per port
   output pfc_pkg::pfc_pin_ctl_t port_j_ctl_out,
   output pfc_pkg::pfc_pin_ctl_t port_k_ctl_out,
   output pfc_pkg::pfc_pin_ctl_t port_l_ctl_out,
   // Raw select words, for the pad ring and debug
   output logic [15:0] port_j_function_select_out,
   output logic [15:0] port_k_function_select_out,
   output logic [15:0] port_l_function_select_out
);
   import pfc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Byte-lane merge of a write into a 16-bit register, then mask fixed bits
   function automatic logic [15:0] merge16(
      input logic [15:0] old_val,
      input logic [15:0] wdata,
      input logic [1:0] be,
      input logic [15:0] mask
   );
      logic [15:0] res;
      res = old_val;
      if (be[0]) begin
         res[7:0] = wdata[7:0];
      end
      if (be[1]) begin
         res[15:8] = wdata[15:8];
      end
      return res & mask;
   endfunction

   // True when any written field of a port carries a code it does not offer
   function automatic logic any_bad(
      input logic [15:0] val,
      input logic [1:0] be,
      input logic [3:0] allow,
      input int unsigned npins
   );
      logic bad;
      logic [1:0] code;
      bad = 1'b0;
      code = 2'h0;
      for (int i = 0; i < 8; i++) begin
         code = val[2*i +: 2];
         if ((i < npins) && be[i/4] && !allow[code]) begin
            bad = 1'b1;
         end
      end
      return bad;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State

   pfc_state_t state_reg;
   pfc_state_t state_next;

   logic req;
   logic commit;
   logic wr_commit;
   logic hit_j;
   logic hit_k;
   logic hit_l;
   logic hit_stat;
   logic hit_sum;
   logic hit_any;
   logic [1:0] be_lo;
   logic [15:0] wdata_lo;
   logic [31:0] sum_word;
   logic [31:0] rd_word;

   pfc_pin_ctl_t ctl_j;
   pfc_pin_ctl_t ctl_k;
   pfc_pin_ctl_t ctl_l;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode, shared by read and write paths
   assign req = avs_read_in | avs_write_in;
   assign hit_j = (avs_address_in == PFC_OFS_J);
   assign hit_k = (avs_address_in == PFC_OFS_K);
   assign hit_l = (avs_address_in == PFC_OFS_L);
   assign hit_stat = (avs_address_in == PFC_OFS_STAT);
   assign hit_sum = (avs_address_in == PFC_OFS_SUMMARY);
   assign hit_any = hit_j | hit_k | hit_l | hit_stat | hit_sum;
   assign be_lo = avs_byteenable_in[1:0];
   assign wdata_lo = avs_writedata_in[15:0];

   // Access completes on the edge that ends the acknowledge cycle
   assign commit = req && (state_reg.bus == PFC_ACK);
   assign wr_commit = commit && avs_write_in;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin decoders; outputs follow the registers, so a write steers the pins
   // from the cycle after the completing edge
   pfc_mode_decode #(
      .NPINS(PFC_PINS_J),
      .ALLOW(PFC_ALLOW_J)
   ) u_dec_j (
      .sel_in(state_reg.j_sel),
      .ctl_out(ctl_j)
   );

   pfc_mode_decode #(
      .NPINS(PFC_PINS_K),
      .ALLOW(PFC_ALLOW_K)
   ) u_dec_k (
      .sel_in(state_reg.k_sel),
      .ctl_out(ctl_k)
   );

   pfc_mode_decode #(
      .NPINS(PFC_PINS_L),
      .ALLOW(PFC_ALLOW_L)
   ) u_dec_l (
      .sel_in(state_reg.l_sel),
      .ctl_out(ctl_l)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Direction summary, a live view of what the pins are doing
   always_comb begin
      sum_word = PFC_RDATA_ZERO;
      sum_word[PFC_SUM_J_OUT +: 8] = ctl_j.out_en;
      sum_word[PFC_SUM_K_OUT +: 8] = ctl_k.out_en;
      sum_word[PFC_SUM_K_IN +: 8] = ctl_k.in_en;
      sum_word[PFC_SUM_L_IN +: 8] = ctl_l.in_en;
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rd_word = PFC_RDATA_ZERO;
      if (hit_j) begin
         rd_word[15:0] = state_reg.j_sel;
      end else if (hit_k) begin
         rd_word[15:0] = state_reg.k_sel;
      end else if (hit_l) begin
         rd_word[15:0] = state_reg.l_sel & PFC_MASK_L;
      end else if (hit_stat) begin
         rd_word[PFC_ST_W-1:0] = state_reg.status;
      end else if (hit_sum) begin
         rd_word = sum_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state: bus handshake, register writes and sticky status
   always_comb begin
      state_next = state_reg;

      // Handshake: one wait cycle, then answer; read data taken on entry to ACK
      case (state_reg.bus)
         PFC_IDLE: begin
            if (req) begin
               state_next.bus = PFC_ACK;
               state_next.rdata = avs_read_in ? rd_word : PFC_RDATA_ZERO;
            end
         end
         PFC_ACK: begin
            state_next.bus = PFC_IDLE;
         end
         default: begin
            state_next.bus = PFC_IDLE;
         end
      endcase

      // Writes land at the completing edge only
      if (wr_commit && hit_j) begin
         state_next.j_sel = merge16(state_reg.j_sel, wdata_lo, be_lo, PFC_MASK_J);
      end
      if (wr_commit && hit_k) begin
         state_next.k_sel = merge16(state_reg.k_sel, wdata_lo, be_lo, PFC_MASK_K);
      end
      if (wr_commit && hit_l) begin
         // Upper byte is masked, so it never holds anything but zero
         state_next.l_sel = merge16(state_reg.l_sel, wdata_lo, be_lo, PFC_MASK_L);
      end

      // Write one to clear; any event in the same cycle sets again below
      if (wr_commit && hit_stat && avs_byteenable_in[0]) begin
         state_next.status = state_reg.status & ~avs_writedata_in[PFC_ST_W-1:0];
      end

      // Flag software slips rather than trusting them never to happen
      if (wr_commit && hit_j && any_bad(wdata_lo, be_lo, PFC_ALLOW_J, PFC_PINS_J)) begin
         state_next.status[PFC_ST_J_BAD] = 1'b1;
      end
      if (wr_commit && hit_l && any_bad(wdata_lo, be_lo, PFC_ALLOW_L, PFC_PINS_L)) begin
         state_next.status[PFC_ST_L_BAD] = 1'b1;
      end
      if (wr_commit && hit_l && avs_byteenable_in[1] && (wdata_lo[15:8] != 8'h00)) begin
         state_next.status[PFC_ST_L_RSV] = 1'b1;
      end
      if (commit && !hit_any) begin
         state_next.status[PFC_ST_UNMAP] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register; all fields clear to documented reset values
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg.bus <= PFC_IDLE;
         state_reg.j_sel <= PFC_RST_J;
         state_reg.k_sel <= PFC_RST_K;
         state_reg.l_sel <= PFC_RST_L;
         state_reg.status <= PFC_RST_STAT;
         state_reg.rdata <= PFC_RDATA_ZERO;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign avs_waitrequest_out = req && (state_reg.bus != PFC_ACK);
   assign avs_readdata_out = state_reg.rdata;

   // Pin controls straight from the decoders of registered selects
   assign port_j_ctl_out = ctl_j;
   assign port_k_ctl_out = ctl_k;
   assign port_l_ctl_out = ctl_l;

   // Raw select words for the pad ring
   assign port_j_function_select_out = state_reg.j_sel;
   assign port_k_function_select_out = state_reg.k_sel;
   assign port_l_function_select_out = state_reg.l_sel;

endmodule

// ### verification/pfc_top_sva.sv
// Checker bound into pfc_top: select word stores and per-pin decode.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/100ps
module pfc_top_sva (
   // Clock, reset and bus
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // Pin side
   input wire pfc_pkg::pfc_pin_ctl_t port_j_ctl_out,
   input wire pfc_pkg::pfc_pin_ctl_t port_k_ctl_out,
   input wire pfc_pkg::pfc_pin_ctl_t port_l_ctl_out,
   input wire logic [15:0] port_j_function_select_out,
   input wire logic [15:0] port_k_function_select_out,
   input wire logic [15:0] port_l_function_select_out
);
   import pfc_pkg::*;
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_b_in);
   ////////////////////////////////////////////////////////////
   // Expected controls; a code the port lacks must steer nothing
   function automatic pfc_pin_ctl_t dec(input logic [15:0] s, input logic [3:0] ok, input int n);
      pfc_pin_ctl_t c;
      c = '0;
      for (int i = 0; i < n; i++) begin
         if (ok[s[2*i+:2]]) begin
            c.alt_sel[i] = s[2*i+:2] == 2'h0;
            c.out_en[i] = s[2*i+:2] == 2'h1;
            c.in_en[i] = s[2*i+1];
            c.pull_up[i] = s[2*i+:2] == 2'h2;
         end
      end
      return c;
   endfunction
   // Accepted write, and its data kept one cycle for the store checks
   logic acc;
   logic [15:0] wd_q;
   pfc_pin_ctl_t jx;
   pfc_pin_ctl_t kx;
   pfc_pin_ctl_t lx;
   assign acc = avs_write_in && !avs_waitrequest_out;
   assign jx = dec(port_j_function_select_out, 4'h3, 8);
   assign kx = dec(port_k_function_select_out, 4'hF, 8);
   assign lx = dec(port_l_function_select_out, 4'h9, 4);
   always_ff @(posedge ref_clk_in) begin
      wd_q <= avs_writedata_in[15:0];
   end
   ////////////////////////////////////////////////////////////
   // Stores land at the accepting edge and show at the next one, never otherwise
   j_store_a:
      assert property (acc && avs_address_in == PFC_OFS_J && avs_byteenable_in[1:0] == 2'h3
         |=> port_j_function_select_out == wd_q) else $error("J select not stored");
   k_store_a:
      assert property (acc && avs_address_in == PFC_OFS_K && avs_byteenable_in[1:0] == 2'h3
         |=> port_k_function_select_out == wd_q) else $error("K select not stored");
   l_store_a:
      assert property (acc && avs_address_in == PFC_OFS_L && avs_byteenable_in[0]
         |=> port_l_function_select_out == {8'h00, wd_q[7:0]}) else $error("L select wrong");
   sel_hold_a:
      assert property (!acc |=> $stable({port_j_function_select_out, port_k_function_select_out,
         port_l_function_select_out})) else $error("Select word moved without a write");
   // Decode follows the stored word in the same cycle
   j_decode_a:
      assert property (port_j_ctl_out == jx) else $error("J pin decode wrong");
   k_route_a:
      assert property ({port_k_ctl_out.alt_sel, port_k_ctl_out.out_en} ==
         {kx.alt_sel, kx.out_en}) else $error("K routing wrong");
   k_input_a:
      assert property ({port_k_ctl_out.in_en, port_k_ctl_out.pull_up} ==
         {kx.in_en, kx.pull_up}) else $error("K input or pull-up wrong");
   l_decode_a:
      assert property (port_l_ctl_out == lx) else $error("L pin decode wrong");
   l_read_a:
      assert property (avs_read_in && !avs_waitrequest_out && avs_address_in == PFC_OFS_L
         |-> avs_readdata_out[31:8] == 24'h00_0000) else $error("L upper bits read nonzero");
endmodule

bind pfc_top pfc_top_sva pfc_top_sva_i (
   .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .port_j_ctl_out(port_j_ctl_out), .port_k_ctl_out(port_k_ctl_out),
   .port_l_ctl_out(port_l_ctl_out),
   .port_j_function_select_out(port_j_function_select_out),
   .port_k_function_select_out(port_k_function_select_out),
   .port_l_function_select_out(port_l_function_select_out)
);

// ### verification/pfc_top_test.sv
// Self-checking bench for pfc_top: register access and pin decode.
// Assumes the slave answers after one wait cycle; the master waits anyway.
`timescale 1ns/100ps
module pfc_top_test;
   import pfc_pkg::*;
   typedef struct {
      logic [4:0] a;
      logic [3:0] be;
      logic [15:0] wd;
      logic [15:0] rd;
      logic [1:0] p;
      logic [31:0] ctl;
   } pfc_row_t;
   // Inputs defined from time zero; outputs indexed J, K, L
   logic ref_clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [4:0] avs_address_in = 5'h00;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0000_0000;
   logic [3:0] avs_byteenable_in = 4'h0;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic [31:0] ctl_o [3];
   logic [15:0] sel_o [3];
   logic [31:0] q;
   int n_fail = 0;
   int n_checks = 0;
   // Write, expected read back, port, expected {alt, out, in, pull-up}
   pfc_row_t rows [9] = '{
      '{PFC_OFS_J, 4'hF, 16'h5555, 16'h5555, 2'h0, 32'h00FF_0000},
      '{PFC_OFS_J, 4'hF, 16'h1B1B, 16'h1B1B, 2'h0, 32'h8844_0000},
      '{PFC_OFS_K, 4'hF, 16'h1B1B, 16'h1B1B, 2'h1, 32'h8844_3322},
      '{PFC_OFS_K, 4'hF, 16'hE4E4, 16'hE4E4, 2'h1, 32'h1122_CC44},
      '{PFC_OFS_K, 4'h1, 16'h0000, 16'hE400, 2'h1, 32'h1F20_C040},
      '{PFC_OFS_L, 4'hF, 16'h00C3, 16'h00C3, 2'h2, 32'h0600_0900},
      '{PFC_OFS_L, 4'hF, 16'hFF3C, 16'h003C, 2'h2, 32'h0900_0600},
      '{PFC_OFS_L, 4'hF, 16'h0066, 16'h0066, 2'h2, 32'h0000_0000},
      '{5'h14, 4'hF, 16'hFFFF, 16'h0000, 2'h3, 32'h0000_0000}
   };
   pfc_top pfc_top_i (
      .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .port_j_ctl_out(ctl_o[0]), .port_k_ctl_out(ctl_o[1]), .port_l_ctl_out(ctl_o[2]),
      .port_j_function_select_out(sel_o[0]), .port_k_function_select_out(sel_o[1]),
      .port_l_function_select_out(sel_o[2])
   );
   ////////////////////////////////////////////////////////////
   // Clock, 25 ns period
   always #12.5 ref_clk_in = ~ref_clk_in;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One access, entered just after a rising edge; waitrequest and read data are
   // taken at the rising edge, before that edge's own updates land; only the
   // watchdog ends a slave that never answers
   task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
      input logic [3:0] be, output logic [31:0] rd);
      avs_address_in <= a;
      avs_writedata_in <= {16'h0000, d};
      avs_byteenable_in <= be;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      do begin
         @(posedge ref_clk_in);
      end while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog, far beyond the roughly 85 cycles the tests need
   initial begin
      repeat (3000) @(posedge ref_clk_in);
      n_fail++;
      results();
   end
   initial begin
      repeat (3) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      @(posedge ref_clk_in);
      for (int p = 0; p < 3; p++) begin
         check(ctl_o[p], p == 2 ? 32'h0F00_0000 : 32'hFF00_0000);
         bus(1'b0, {1'h0, 2'(p), 2'h0}, 16'h0000, 4'hF, q);
         check(q, 32'h0000_0000);
         @(posedge ref_clk_in);
      end
      $display("reset values done");
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].wd, rows[i].be, q);
         #1;
         if (rows[i].p != 2'h3) begin
            check(ctl_o[rows[i].p], rows[i].ctl);
            check({16'h0000, sel_o[rows[i].p]}, {16'h0000, rows[i].rd});
         end
         @(posedge ref_clk_in);
         bus(1'b0, rows[i].a, 16'h0000, 4'hF, q);
         check(q, {16'h0000, rows[i].rd});
         @(posedge ref_clk_in);
         $display("row %0d done", i);
      end
      // Software slips from the rows above must all be flagged, then clear
      bus(1'b0, PFC_OFS_STAT, 16'h0000, 4'hF, q);
      check(q, 32'h0000_000F);
      @(posedge ref_clk_in);
      // Live direction view: J 1B1B, K E400, L 0066 (all L codes refused)
      bus(1'b0, PFC_OFS_SUMMARY, 16'h0000, 4'hF, q);
      check(q, 32'h00C0_2044);
      @(posedge ref_clk_in);
      bus(1'b1, PFC_OFS_STAT, 16'h000F, 4'h1, q);
      @(posedge ref_clk_in);
      bus(1'b0, PFC_OFS_STAT, 16'h0000, 4'hF, q);
      check(q, 32'h0000_0000);
      @(posedge ref_clk_in);
      $display("status and summary done");
      // Reset in mid-run clears every stored word
      rst_b_in <= 1'b0;
      @(posedge ref_clk_in);
      #1;
      for (int p = 0; p < 3; p++) begin
         check({16'h0000, sel_o[p]}, 32'h0000_0000);
      end
      check(ctl_o[1], 32'hFF00_0000);
      @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      @(posedge ref_clk_in);
      // First access right after release must already be served
      bus(1'b0, PFC_OFS_K, 16'h0000, 4'hF, q);
      check(q, 32'h0000_0000);
      @(posedge ref_clk_in);
      $display("mid-run reset done");
      results();
   end
endmodule
